// [verilog/spi_port_defs.svh]
/*
  Constants of the serial port: control and prescaler field positions, reset values,
  rate bases and byte framing. Assumes inclusion by bare name from the design file.
*/
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CR_IRQ_ENABLE   7
`define CR_PIN_OE       6
`define CR_IRQ_SEL      5
`define CR_CTRL_SEL     4
`define CR_IDLE_LEVEL   3
`define CR_PHASE        2
`define CR_RATE_HI      1
`define CR_RATE_LO      0
`define CR_RESET        8'h00

// ----------------------------------------
// clock divider register fields
// ----------------------------------------
`define PR_HALF_RATE    3
`define PR_PRESC_HI     2
`define PR_PRESC_LO     0
`define PR_RESET        4'h0

// ----------------------------------------
// half-period bases for the rate codes (divide by 2, 4, 16, 32)
// ----------------------------------------
`define RATE_HALF_00    9'h001
`define RATE_HALF_01    9'h002
`define RATE_HALF_10    9'h008
`define RATE_HALF_11    9'h010

// ----------------------------------------
// framing and buffering
// ----------------------------------------
`define EDGES_PER_BYTE  5'h10
`define DATA_W          8
`define RX_FIFO_DEPTH   8

`endif

// [verilog/spi_types_pkg.sv]
/*
  Types shared by the serial port design. Assumes nothing of its surroundings.
*/
package spi_types_pkg;
  typedef enum {
    xf_idle,
    xf_controller,
    xf_target
  } xfer_state_t;
endpackage

// [verilog/spi_master_slave_port.sv]
/*
  Full-duplex byte-wide serial port, controller or target, with a receive stream FIFO.
  Assumes all pin inputs and software strobes are synchronous to clk; strobes are
  one-cycle pulses and ce low freezes every flip-flop.
*/
`timescale 1ns/1ps
`include "spi_port_defs.svh"

// ----------------------------------------
// receive stream fifo
// ----------------------------------------
module rx_stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q, wr_ptr_d;
  logic [AW-1:0]    rd_ptr_q, rd_ptr_d;
  logic [AW:0]      cnt_q,    cnt_d;
  logic             ov_q,     ov_d;
  logic [WIDTH-1:0] od_q,     od_d;
  logic             push;
  logic             pop;

  // the output stage is a register so the consumer sees flop outputs
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = ov_q;
  assign out_data  = od_q;

  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    ov_d     = ov_q;
    od_d     = od_q;
    push     = in_valid && in_ready;
    pop      = (cnt_q != '0) && (!ov_q || out_ready);
    if (ov_q && out_ready) begin
      ov_d = 1'b0;
    end
    if (pop) begin
      od_d     = mem_q[rd_ptr_q];
      ov_d     = 1'b1;
      rd_ptr_d = rd_ptr_q + 1'b1;
    end
    if (push) begin
      wr_ptr_d = wr_ptr_q + 1'b1;
    end
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
      ov_q     <= 1'b0;
      od_q     <= '0;
    end else if (ce) begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q    <= cnt_d;
      ov_q     <= ov_d;
      od_q     <= od_d;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end
endmodule

// ----------------------------------------
// serial port
// ----------------------------------------
module spi_master_slave_port (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       data_buffer_wr,
  input  wire logic       data_buffer_rd,
  input  wire logic [7:0] data_buffer_wdata,
  input  wire logic       control_reg_wr,
  input  wire logic [7:0] control_reg_wdata,
  input  wire logic       clock_divider_wr,
  input  wire logic [3:0] clock_divider_wdata,
  input  wire logic       status_reg_access,
  input  wire logic       sck_pin,
  input  wire logic       mosi_pin,
  input  wire logic       miso_pin,
  input  wire logic       slave_select_n,
  input  wire logic       rx_stream_ready,
  output logic            sck_drive,
  output logic            sck_drive_en,
  output logic            mosi_drive,
  output logic            mosi_drive_en,
  output logic            miso_drive,
  output logic            miso_drive_en,
  output logic [7:0]      data_buffer_rdata,
  output logic [7:0]      control_reg_rdata,
  output logic            transfer_done_flag,
  output logic            write_collision_flag,
  output logic            mode_fault_flag,
  output logic            irq,
  output logic            rx_stream_valid,
  output logic [7:0]      rx_stream_data
);
  spi_types_pkg::xfer_state_t xs_q, xs_d;

  logic [7:0] cr_q,    cr_d;
  logic [3:0] pr_q,    pr_d;
  logic [4:0] edge_q,  edge_d;
  logic [8:0] div_q,   div_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] rx_q,    rx_d;
  logic       out_q,   out_d;
  logic       sck_q,   sck_d;
  logic       sck_oe_q, sck_oe_d;
  logic       miso_oe_q, miso_oe_d;
  logic       done_q,  done_d;
  logic       write_collision_flag_q,  write_collision_flag_d;
  logic       mode_fault_flag_q,  mode_fault_flag_d;
  logic       seen_q,  seen_d;
  logic       mseen_q, mseen_d;
  logic       irq_q,   irq_d;
  logic       sck_prev_q;
  logic [4:0] tog_q,   tog_d;

  logic       ctrl;
  logic       clock_phase_select;
  logic [8:0] base;
  logic [8:0] half_w;
  logic       tick;
  logic       stall;
  logic       tgt_edge;
  logic       busy;
  logic       wr_blocked;
  logic       wr_ok;
  logic       collision;
  logic       edge_go;
  logic       done_evt;
  logic [4:0] k;
  logic       sin;
  logic       fifo_rdy;

  assign ctrl = cr_q[`CR_CTRL_SEL];
  assign clock_phase_select = cr_q[`CR_PHASE];

  // ----------------------------------------
  // bit clock generation
  // ----------------------------------------
  always_comb begin
    unique case (cr_q[`CR_RATE_HI:`CR_RATE_LO])
      2'h0: base = `RATE_HALF_00;
      2'h1: base = `RATE_HALF_01;
      2'h2: base = `RATE_HALF_10;
      2'h3: base = `RATE_HALF_11;
    endcase
    half_w = 9'(base * ({6'h00, pr_q[`PR_PRESC_HI:`PR_PRESC_LO]} + 9'h001));
    if (pr_q[`PR_HALF_RATE]) begin
      half_w = {half_w[7:0], 1'b0};
    end
  end

  assign tick     = (div_q == half_w - 9'h001);
  // a full fifo holds the last edge so no controller byte is lost
  assign stall    = (edge_q == `EDGES_PER_BYTE - 5'h01) && !fifo_rdy;
  assign tgt_edge = !ctrl && !slave_select_n && (sck_pin != sck_prev_q);
  // phase set lets select stay low across bytes, so only edges mark activity
  assign busy     = (xs_q == spi_types_pkg::xf_controller) ||
                    (!ctrl && (clock_phase_select ? (edge_q != 5'h00) : !slave_select_n));
  assign wr_blocked = done_q && !seen_q;
  assign wr_ok      = data_buffer_wr && !wr_blocked && !busy;
  assign collision  = data_buffer_wr && !wr_blocked && busy;
  assign k          = edge_q + 5'h01;
  assign sin        = ctrl ? miso_pin : mosi_pin;

  // ----------------------------------------
  // transfer engine and software state
  // ----------------------------------------
  always_comb begin
    xs_d     = xs_q;
    edge_d   = edge_q;
    div_d    = div_q;
    shift_d  = shift_q;
    out_d    = out_q;
    sck_d    = (xs_q == spi_types_pkg::xf_controller) ? sck_q : cr_q[`CR_IDLE_LEVEL];
    edge_go  = 1'b0;
    done_evt = 1'b0;
    tog_d    = (sck_d != sck_q) ? tog_q + 5'h01 : tog_q;
    unique case (xs_q)
      spi_types_pkg::xf_idle: begin
        if (ctrl) begin
          if (wr_ok && cr_q[`CR_PIN_OE]) begin
            shift_d = data_buffer_wdata;
            out_d   = data_buffer_wdata[7];
            edge_d  = 5'h00;
            div_d   = 9'h000;
            tog_d   = 5'h00;
            xs_d    = spi_types_pkg::xf_controller;
          end
        end else begin
          if (wr_ok) begin
            shift_d = data_buffer_wdata;
          end
          if (!slave_select_n && !clock_phase_select) begin
            out_d = shift_d[7];
          end
          edge_go = tgt_edge;
        end
      end
      spi_types_pkg::xf_controller: begin
        if (!ctrl) begin
          xs_d   = spi_types_pkg::xf_idle;
          edge_d = 5'h00;
        end else if (tick && !stall) begin
          div_d   = 9'h000;
          sck_d   = ~sck_q;
          tog_d   = tog_q + 5'h01;
          edge_go = 1'b1;
        end else if (!tick) begin
          div_d = div_q + 9'h001;
        end
      end
      spi_types_pkg::xf_target: begin
        if (ctrl || (slave_select_n && !clock_phase_select) || slave_select_n) begin
          xs_d   = spi_types_pkg::xf_idle;
          edge_d = 5'h00;
        end else begin
          edge_go = tgt_edge;
        end
      end
    endcase
    if (edge_go) begin
      edge_d = k;
      if (!ctrl) begin
        xs_d = spi_types_pkg::xf_target;
      end
      // sample edges are odd with phase clear, even with phase set
      if (k[0] ^ clock_phase_select) begin
        shift_d = {shift_q[6:0], sin};
      end else begin
        out_d = shift_q[7];
      end
      if (k == `EDGES_PER_BYTE) begin
        done_evt = 1'b1;
        edge_d   = 5'h00;
        xs_d     = spi_types_pkg::xf_idle;
      end
    end
  end

  always_comb begin
    cr_d    = cr_q;
    pr_d    = pr_q;
    done_d  = done_q;
    write_collision_flag_d  = write_collision_flag_q;
    mode_fault_flag_d  = mode_fault_flag_q;
    seen_d  = seen_q;
    mseen_d = mseen_q;
    rx_d    = rx_q;
    if (status_reg_access && (done_q || write_collision_flag_q)) begin
      seen_d = 1'b1;
    end
    if ((data_buffer_wr || data_buffer_rd) && seen_q) begin
      done_d = 1'b0;
      write_collision_flag_d = 1'b0;
      seen_d = 1'b0;
    end
    if (collision) begin
      write_collision_flag_d = 1'b1;
    end
    if (done_evt) begin
      done_d = 1'b1;
      if (!done_q) begin
        rx_d = shift_d;
      end
    end
    if (status_reg_access && mode_fault_flag_q) begin
      mseen_d = 1'b1;
    end
    if (control_reg_wr) begin
      cr_d = control_reg_wdata;
      if (mode_fault_flag_q && !mseen_q) begin
        cr_d[`CR_PIN_OE]   = cr_q[`CR_PIN_OE];
        cr_d[`CR_CTRL_SEL] = cr_q[`CR_CTRL_SEL];
      end
      if (mseen_q) begin
        mode_fault_flag_d  = 1'b0;
        mseen_d = 1'b0;
      end
    end
    if (clock_divider_wr) begin
      pr_d = clock_divider_wdata;
    end
    if (ctrl && !slave_select_n) begin
      mode_fault_flag_d             = 1'b1;
      cr_d[`CR_PIN_OE]   = 1'b0;
      cr_d[`CR_CTRL_SEL] = 1'b0;
    end
    irq_d     = cr_d[`CR_IRQ_ENABLE] && cr_d[`CR_IRQ_SEL] && (done_d ^ mode_fault_flag_d);
    sck_oe_d  = cr_d[`CR_PIN_OE] && cr_d[`CR_CTRL_SEL];
    miso_oe_d = cr_d[`CR_PIN_OE] && !cr_d[`CR_CTRL_SEL] && !slave_select_n;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      xs_q       <= spi_types_pkg::xf_idle;
      cr_q       <= `CR_RESET;
      pr_q       <= `PR_RESET;
      edge_q     <= 5'h00;
      div_q      <= 9'h000;
      shift_q    <= 8'h00;
      rx_q       <= 8'h00;
      out_q      <= 1'b0;
      sck_q      <= 1'b0;
      sck_oe_q   <= 1'b0;
      miso_oe_q  <= 1'b0;
      done_q     <= 1'b0;
      write_collision_flag_q     <= 1'b0;
      mode_fault_flag_q     <= 1'b0;
      seen_q     <= 1'b0;
      mseen_q    <= 1'b0;
      irq_q      <= 1'b0;
      sck_prev_q <= 1'b0;
      tog_q      <= 5'h00;
    end else if (ce) begin
      xs_q       <= xs_d;
      cr_q       <= cr_d;
      pr_q       <= pr_d;
      edge_q     <= edge_d;
      div_q      <= div_d;
      shift_q    <= shift_d;
      rx_q       <= rx_d;
      out_q      <= out_d;
      sck_q      <= sck_d;
      sck_oe_q   <= sck_oe_d;
      miso_oe_q  <= miso_oe_d;
      done_q     <= done_d;
      write_collision_flag_q     <= write_collision_flag_d;
      mode_fault_flag_q     <= mode_fault_flag_d;
      seen_q     <= seen_d;
      mseen_q    <= mseen_d;
      irq_q      <= irq_d;
      sck_prev_q <= sck_pin;
      tog_q      <= tog_d;
    end
  end

  // ----------------------------------------
  // receive stream
  // ----------------------------------------
  // target bytes cannot be held back, so a full fifo drops them from the stream only
  rx_stream_fifo #(
    .WIDTH (`DATA_W),
    .DEPTH (`RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (done_evt),
    .in_data   (shift_d),
    .in_ready  (fifo_rdy),
    .out_valid (rx_stream_valid),
    .out_data  (rx_stream_data),
    .out_ready (rx_stream_ready)
  );

  assign sck_drive            = sck_q;
  assign sck_drive_en         = sck_oe_q;
  assign mosi_drive           = out_q;
  assign mosi_drive_en        = sck_oe_q;
  assign miso_drive           = out_q;
  assign miso_drive_en        = miso_oe_q;
  assign data_buffer_rdata    = rx_q;
  assign control_reg_rdata    = cr_q;
  assign transfer_done_flag   = done_q;
  assign write_collision_flag = write_collision_flag_q;
  assign mode_fault_flag      = mode_fault_flag_q;
  assign irq                  = irq_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_start;
    @(posedge clk) disable iff (rst || !ce)
    (xs_q == spi_types_pkg::xf_idle && ctrl && wr_ok && cr_q[`CR_PIN_OE])
      |=> (xs_q == spi_types_pkg::xf_controller) && (shift_q == $past(data_buffer_wdata));
  endproperty
  a_start: assert property (p_start) else $error("controller write did not start");

  property p_msb;
    @(posedge clk) disable iff (rst || !ce)
    (xs_q == spi_types_pkg::xf_idle && ctrl && wr_ok && cr_q[`CR_PIN_OE])
      |=> mosi_drive == $past(data_buffer_wdata[7]);
  endproperty
  a_msb: assert property (p_msb) else $error("first data bit is not the msb");

  property p_rate;
    @(posedge clk) disable iff (rst || !ce)
    (xs_q == spi_types_pkg::xf_controller && ctrl && !tick) |=> $stable(sck_drive);
  endproperty
  a_rate: assert property (p_rate) else $error("clock moved before divider expired");

  property p_fast;
    @(posedge clk) disable iff (rst || !ce)
    (xs_q == spi_types_pkg::xf_controller && ctrl && half_w == 9'h001 && !stall)
      |=> sck_drive != $past(sck_drive);
  endproperty
  a_fast: assert property (p_fast) else $error("divide by two rate not kept");

  property p_pulses;
    @(posedge clk) disable iff (rst || !ce)
    (done_evt && xs_q == spi_types_pkg::xf_controller) |=> tog_q == 5'h10;
  endproperty
  a_pulses: assert property (p_pulses) else $error("byte not sixteen clock edges");

  property p_irq;
    @(posedge clk) disable iff (rst || !ce)
    (done_evt && !mode_fault_flag_q && cr_q[`CR_IRQ_ENABLE] && cr_q[`CR_IRQ_SEL] && !control_reg_wr
      && !(ctrl && !slave_select_n)) |=> irq && transfer_done_flag;
  endproperty
  a_irq: assert property (p_irq) else $error("done without interrupt");

  property p_rxbuf;
    @(posedge clk) disable iff (rst || !ce)
    (done_evt && !done_q) |=> data_buffer_rdata == shift_q;
  endproperty
  a_rxbuf: assert property (p_rxbuf) else $error("receive buffer not loaded");

  property p_clear;
    @(posedge clk) disable iff (rst || !ce)
    (done_q && seen_q && data_buffer_rd && !done_evt) |=> !transfer_done_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("done flag not cleared");

  property p_ignore;
    @(posedge clk) disable iff (rst || !ce)
    (data_buffer_wr && done_q && !seen_q && xs_q == spi_types_pkg::xf_idle && !edge_go)
      |=> $stable(shift_q) && !(write_collision_flag_q && !$past(write_collision_flag_q));
  endproperty
  a_ignore: assert property (p_ignore) else $error("write taken while done set");

  property p_idle;
    @(posedge clk) disable iff (rst || !ce)
    (xs_q == spi_types_pkg::xf_idle && $past(xs_q == spi_types_pkg::xf_idle)
      && $stable(cr_q[`CR_IDLE_LEVEL])) |-> sck_drive == cr_q[`CR_IDLE_LEVEL];
  endproperty
  a_idle: assert property (p_idle) else $error("clock not at idle level");

  property p_write_collision_flag;
    @(posedge clk) disable iff (rst || !ce)
    collision |=> write_collision_flag && (edge_q == $past(edge_d));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

  property p_fault;
    @(posedge clk) disable iff (rst || !ce)
    (ctrl && !slave_select_n) |=> mode_fault_flag && !control_reg_rdata[`CR_CTRL_SEL]
      && !control_reg_rdata[`CR_PIN_OE] && !sck_drive_en;
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault not taken");

  property p_refuse;
    @(posedge clk) disable iff (rst || !ce)
    (mode_fault_flag_q && !mseen_q && control_reg_wr) |=> !control_reg_rdata[`CR_CTRL_SEL] && mode_fault_flag;
  endproperty
  a_refuse: assert property (p_refuse) else $error("enable set during fault");

  property p_keep;
    @(posedge clk) disable iff (rst || !ce)
    (done_evt && done_q) |=> $stable(data_buffer_rdata);
  endproperty
  a_keep: assert property (p_keep) else $error("later byte overwrote buffer");

  c_ctrl_byte: cover property (@(posedge clk) done_evt && ctrl);
  c_tgt_byte:  cover property (@(posedge clk) done_evt && !ctrl);
  c_collision: cover property (@(posedge clk) collision);
  c_fault:     cover property (@(posedge clk) ctrl && !slave_select_n);
endmodule

// [bench/spi_target_model.sv]
/*
  Behavioural serial target that answers the port while it runs as controller.
  Assumes the port's clock and data outputs feed it directly and its select comes
  from the bench.
*/
`timescale 1ns/1ps

// ----------------------------------------
// serial target model
// ----------------------------------------
module spi_target_model (
  input  wire logic       sel_n,
  input  wire logic       phase,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh_q = 8'h00;
  int         cnt  = 0;

  // reload on each select so a stale byte never leaks into the next frame
  always @(negedge sel_n) begin
    sh_q = tx_byte;
    cnt  = 0;
  end

  // edges are counted, not levels, so idle level needs no input here
  always @(sck) begin
    if (!sel_n) begin
      if (cnt[0] == phase) begin
        rx_byte = {rx_byte[6:0], mosi};
      end else if (!(phase && cnt == 0)) begin
        sh_q = {sh_q[6:0], 1'b0};
      end
      cnt = cnt + 1;
    end
  end

  // unselected, or before the first edge with phase set: inverted, never a helpful level
  assign miso = (sel_n || (phase && cnt == 0)) ? ~sh_q[7] : sh_q[7];
endmodule

// [bench/test_spi_master_slave_port.sv]
/*
  Self-checking bench of the serial port as controller with a target model, and as target.
  Assumes the design files and the target model are compiled first.
*/
`timescale 1ns/1ps

// ----------------------------------------
// bench top
// ----------------------------------------
module test_spi_master_slave_port;
  logic       clk = 1'b0, rst = 1'b1, ce = 1'b1, rnd = 1'b0;
  logic       data_buffer_wr = 1'b0, data_buffer_rd = 1'b0, control_reg_wr = 1'b0;
  logic       clock_divider_wr = 1'b0, status_reg_access = 1'b0, slave_select_n = 1'b1;
  logic       rx_stream_ready = 1'b0, tgt_sel_n = 1'b1, ph = 1'b0;
  logic       tm = 1'b0, tsck = 1'b0, tmosi = 1'b0;
  logic [7:0] data_buffer_wdata = 8'h00, control_reg_wdata = 8'h00, tgt_byte = 8'h00, cfg;
  logic [3:0] clock_divider_wdata = 4'h0;
  logic       sck_drive, sck_drive_en, mosi_drive, mosi_drive_en, miso_drive, miso_drive_en;
  logic       transfer_done_flag, write_collision_flag, mode_fault_flag, irq;
  logic       rx_stream_valid, tgt_miso;
  logic [7:0] data_buffer_rdata, control_reg_rdata, rx_stream_data, tgt_rx;
  int         err_total = 0, cmp_count = 0, cyc = 0;
  logic [7:0] exp_q[$];

  spi_master_slave_port dut (.clk(clk), .rst(rst), .ce(ce), .data_buffer_wr(data_buffer_wr),
    .data_buffer_rd(data_buffer_rd), .data_buffer_wdata(data_buffer_wdata),
    .control_reg_wr(control_reg_wr), .control_reg_wdata(control_reg_wdata),
    .clock_divider_wr(clock_divider_wr), .clock_divider_wdata(clock_divider_wdata),
    .status_reg_access(status_reg_access), .sck_pin(tm ? tsck : sck_drive),
    .mosi_pin(tm ? tmosi : mosi_drive),
    .miso_pin(tgt_miso), .slave_select_n(slave_select_n), .rx_stream_ready(rx_stream_ready),
    .sck_drive(sck_drive), .sck_drive_en(sck_drive_en), .mosi_drive(mosi_drive),
    .mosi_drive_en(mosi_drive_en), .miso_drive(miso_drive), .miso_drive_en(miso_drive_en),
    .data_buffer_rdata(data_buffer_rdata), .control_reg_rdata(control_reg_rdata),
    .transfer_done_flag(transfer_done_flag), .write_collision_flag(write_collision_flag),
    .mode_fault_flag(mode_fault_flag), .irq(irq), .rx_stream_valid(rx_stream_valid),
    .rx_stream_data(rx_stream_data));

  spi_target_model partner (.sel_n(tgt_sel_n), .phase(ph), .sck(sck_drive),
    .mosi(mosi_drive), .tx_byte(tgt_byte), .miso(tgt_miso), .rx_byte(tgt_rx));

  initial begin
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task results;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task tick;
    @(posedge clk);
    #2;
  endtask

  task wr_ctl(input logic [7:0] v);
    control_reg_wdata = v;
    control_reg_wr    = 1'b1;
    tick;
    control_reg_wr    = 1'b0;
  endtask

  task wr_dat(input logic [7:0] v);
    data_buffer_wdata = v;
    data_buffer_wr    = 1'b1;
    tick;
    data_buffer_wr    = 1'b0;
  endtask

  task sts;
    status_reg_access = 1'b1;
    tick;
    status_reg_access = 1'b0;
  endtask

  // one controller byte; hold means the stream is full and the byte must wait
  task run(input logic [7:0] m, input logic [7:0] s, input logic hold, input logic ie);
    int n;
    tgt_byte  = s;
    tgt_sel_n = 1'b0;
    exp_q.push_back(s);
    wr_dat(m);
    tick;
    chk(transfer_done_flag, 0);
    chk(write_collision_flag, 0);
    repeat (2) tick;
    wr_dat(~m);
    tick;
    chk(write_collision_flag, 1);
    if (hold) begin
      repeat (500) tick;
      chk(transfer_done_flag, 0);
      rx_stream_ready = 1'b1;
    end
    for (n = 0; n < 5000 && transfer_done_flag !== 1'b1; n++) tick;
    tick;
    chk(transfer_done_flag, 1);
    chk(data_buffer_rdata, s);
    chk(tgt_rx, m);
    chk(irq, ie);
    wr_dat(~s);
    tick;
    chk(transfer_done_flag, 1);
    chk(sck_drive, cfg[3]);
    sts;
    tick;
    chk(transfer_done_flag, 1);
    tgt_sel_n = 1'b1;
    tick;
  endtask

  // one target byte; the bench acts as controller, two clk cycles per sck half period
  task tgt_run(input logic [7:0] m, input logic [7:0] s, input logic p);
    int         k;
    logic [7:0] got;
    got = 8'h00;
    tm  = 1'b1;
    wr_ctl({5'h08, p, 2'h0});
    wr_dat(s);
    exp_q.push_back(m);
    tmosi          = m[7];
    slave_select_n = 1'b0;
    repeat (2) tick;
    chk(miso_drive_en, 1);
    chk(mosi_drive_en, 0);
    for (k = 1; k <= 16; k++) begin
      tsck = ~tsck;
      if (k[0] ^ p) got = {got[6:0], miso_drive};
      else if (k < 16) tmosi = m[7 - (k - p) / 2];
      if (k == 4) wr_dat(~s);
      else tick;
      tick;
    end
    tick;
    chk(got, s);
    chk(data_buffer_rdata, m);
    chk(transfer_done_flag, 1);
    chk(write_collision_flag, 1);
    sts;
    slave_select_n = 1'b1;
    tick;
  endtask

  // ----------------------------------------
  // stream watcher, stall driver and timeout
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst && rx_stream_valid === 1'b1 && rx_stream_ready === 1'b1) begin
      chk(rx_stream_data, (exp_q.size() > 0) ? exp_q.pop_front() : ~rx_stream_data);
    end
    if (rnd) rx_stream_ready <= #2 1'($urandom);
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      results;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int i, n;
    void'($urandom(32'h9586));
    repeat (4) @(posedge clk);
    #2;
    rst = 1'b0;
    tick;
    // nine bytes fill the stream with its consumer stalled; the tenth must wait
    for (i = 0; i < 10; i++) begin
      cfg = {i[0], 1'b1, i[0], 1'b1, 2'($urandom), 2'(i)};
      ph  = cfg[2];
      clock_divider_wdata = 4'($urandom);
      clock_divider_wr    = 1'b1;
      tick;
      clock_divider_wr    = 1'b0;
      wr_ctl(cfg);
      tick;
      chk(sck_drive, cfg[3]);
      chk(sck_drive_en, 1);
      run(8'($urandom), 8'($urandom), i == 9, i[0]);
    end
    tgt_run(8'($urandom), 8'($urandom), 1'b0);
    tgt_run(8'($urandom), 8'($urandom), 1'b1);
    rnd = 1'b1;
    for (n = 0; n < 500 && exp_q.size() > 0; n++) tick;
    chk(8'(exp_q.size()), 0);
    data_buffer_rd = 1'b1;
    tick;
    data_buffer_rd = 1'b0;
    tick;
    chk(transfer_done_flag, 0);
    wr_ctl(8'hF0);
    slave_select_n = 1'b0;
    repeat (3) tick;
    chk(mode_fault_flag, 1);
    chk(control_reg_rdata, 8'hA0);
    chk(irq, 1);
    slave_select_n = 1'b1;
    wr_ctl(8'hF0);
    tick;
    chk(control_reg_rdata, 8'hA0);
    chk(mode_fault_flag, 1);
    sts;
    wr_ctl(8'hF0);
    tick;
    chk(mode_fault_flag, 0);
    chk(control_reg_rdata, 8'hF0);
    results;
  end
endmodule
